/* File: verilog/adcrs_defs.svh */
// Constants of the result-slot block: offsets, field positions, reset values.
// How it works
// - Result sits in bits 15..6; bits 31..16 and 5..2 read zero; read-only.
// - Bit 1 overrun sets when a new result replaces an unread one.
// - Reading the register clears its overrun bit.
// - Bit 0 result-stored sets whenever a result is written into the slot.
// - Reading the register clears its result-stored bit, unless a result is written into the slot in the same cycle.
`ifndef ADCRS_DEFS_SVH
`define ADCRS_DEFS_SVH
`define ADCRS_OFF_SLOT_TWO 8'h00
`define ADCRS_OFF_SLOT_THREE 8'h04
`define ADCRS_OFF_SLOT_FOUR 8'h08
`define ADCRS_OFF_IRQ_STATUS 8'h0C
`define ADCRS_OFF_IRQ_MASK 8'h10
`define ADCRS_VALUE_LSB 6
`define ADCRS_VALUE_MSB 15
`define ADCRS_OVERRUN_BIT 1
`define ADCRS_STORED_BIT 0
`define ADCRS_RESET_WORD 32'h0000_0000
`define ADCRS_RESET_IRQ 6'h00
`endif

/* File: verilog/adcrs_pkg.sv */
// Types shared by the result-slot block.
package adcrs_pkg;
  typedef enum logic [1:0] {
    ADCRS_SLOT_TWO = 2'h0,
    ADCRS_SLOT_THREE = 2'h1,
    ADCRS_SLOT_FOUR = 2'h2
  } adcrs_slot_t;
endpackage

/* File: verilog/adcrs_result_slots.sv */
// Result slots two to four of the converter, with read-clear flags and interrupt.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "adcrs_defs.svh"
module adcrs_result_slots
#(
  parameter int RESULT_WIDTH = 10,
  parameter int ADDR_WIDTH = 8
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [ADDR_WIDTH-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [31:0] o_rdata,
  input wire logic i_result_write,
  input wire logic [1:0] i_result_slot,
  input wire logic [RESULT_WIDTH-1:0] i_result_value,
  output logic o_irq
);

  // Refuse sizes that the fixed register layout cannot hold.
  if (RESULT_WIDTH != `ADCRS_VALUE_MSB - `ADCRS_VALUE_LSB + 1)
  begin : g_bad_width
    $error("adcrs_result_slots: result field is fixed at ten bits");
  end
  if (ADDR_WIDTH < 5)
  begin : g_bad_addr
    $error("adcrs_result_slots: address too narrow for the map");
  end

  localparam int NSLOT = 3;

  logic [RESULT_WIDTH-1:0] value [NSLOT];
  logic [NSLOT-1:0] stored;
  logic [NSLOT-1:0] overrun;
  logic [NSLOT-1:0] slot_read;
  logic [NSLOT-1:0] slot_write;
  logic [2*NSLOT-1:0] irq_status;
  logic [2*NSLOT-1:0] irq_mask;
  logic [2*NSLOT-1:0] next_events;
  logic [31:0] next_rdata;

  // Maps a register offset to its slot index, or all ones if none.
  function automatic logic [1:0] slot_of(input logic [ADDR_WIDTH-1:0] a);
    logic [1:0] s;
    s = 2'h3;
    if (a == ADDR_WIDTH'(`ADCRS_OFF_SLOT_TWO))
      s = 2'(adcrs_pkg::ADCRS_SLOT_TWO);
    else if (a == ADDR_WIDTH'(`ADCRS_OFF_SLOT_THREE))
      s = 2'(adcrs_pkg::ADCRS_SLOT_THREE);
    else if (a == ADDR_WIDTH'(`ADCRS_OFF_SLOT_FOUR))
      s = 2'(adcrs_pkg::ADCRS_SLOT_FOUR);
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-slot storage and flags.

  genvar g;
  generate
    for (g = 0; g < NSLOT; g++)
    begin : g_slot
      assign slot_read[g] = i_read && (slot_of(i_addr) == 2'(g));
      assign slot_write[g] = i_result_write && (i_result_slot == 2'(g));

      always_ff @(posedge i_clock or posedge i_rst)
      begin
        if (i_rst)
          value[g] <= '0;
        else if (slot_write[g])
          value[g] <= i_result_value;
      end

      // A new result wins over a read clear of the stored flag in the same cycle; the overrun flag still clears.
      always_ff @(posedge i_clock or posedge i_rst)
      begin
        if (i_rst)
        begin
          stored[g] <= 1'b0;
          overrun[g] <= 1'b0;
        end
        else if (slot_write[g])
        begin
          stored[g] <= 1'b1;
          if (stored[g] && !slot_read[g])
            overrun[g] <= 1'b1;
          else if (slot_read[g])
            overrun[g] <= 1'b0;
        end
        else if (slot_read[g])
        begin
          stored[g] <= 1'b0;
          overrun[g] <= 1'b0;
        end
      end

      assign next_events[2*g] = slot_write[g];
      assign next_events[2*g+1] = slot_write[g] && stored[g] && !slot_read[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear; set wins over clear.

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      irq_status <= `ADCRS_RESET_IRQ;
    else if (i_write && i_addr == ADDR_WIDTH'(`ADCRS_OFF_IRQ_STATUS))
      irq_status <= (irq_status & ~i_wdata[2*NSLOT-1:0]) | next_events;
    else
      irq_status <= irq_status | next_events;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      irq_mask <= `ADCRS_RESET_IRQ;
    else if (i_write && i_addr == ADDR_WIDTH'(`ADCRS_OFF_IRQ_MASK))
      irq_mask <= i_wdata[2*NSLOT-1:0];
  end

  assign o_irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; flags as they stood before.

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (slot_of(i_addr) != 2'h3)
    begin
      next_rdata[`ADCRS_VALUE_MSB:`ADCRS_VALUE_LSB] = value[slot_of(i_addr)];
      next_rdata[`ADCRS_OVERRUN_BIT] = overrun[slot_of(i_addr)];
      next_rdata[`ADCRS_STORED_BIT] = stored[slot_of(i_addr)];
    end
    else if (i_addr == ADDR_WIDTH'(`ADCRS_OFF_IRQ_STATUS))
      next_rdata[2*NSLOT-1:0] = irq_status;
    else if (i_addr == ADDR_WIDTH'(`ADCRS_OFF_IRQ_MASK))
      next_rdata[2*NSLOT-1:0] = irq_mask;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= `ADCRS_RESET_WORD;
    else if (i_read)
      o_rdata <= next_rdata;
    else
      o_rdata <= `ADCRS_RESET_WORD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Every slot gets the same set of flag and value checks.
  generate
    for (g = 0; g < NSLOT; g++)
    begin : g_check
      a_stored_sets: assert property (@(posedge i_clock) disable iff (i_rst)
        slot_write[g] |=> stored[g])
        else $error("stored flag not set after result write");
      a_overrun_sets: assert property (@(posedge i_clock) disable iff (i_rst)
        slot_write[g] && stored[g] && !slot_read[g] |=> overrun[g])
        else $error("overrun not set on unread replace");
      a_overrun_stored: assert property (@(posedge i_clock) disable iff (i_rst)
        overrun[g] |-> stored[g])
        else $error("overrun flag without a stored result");
      a_overrun_read_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        slot_read[g] && !slot_write[g] |=> !overrun[g])
        else $error("overrun not cleared by read");
      a_stored_read_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        slot_read[g] && !slot_write[g] |=> !stored[g])
        else $error("stored flag not cleared by read");
      a_flags_hold: assert property (@(posedge i_clock) disable iff (i_rst)
        !slot_write[g] && !slot_read[g]
          |=> stored[g] == $past(stored[g]) && overrun[g] == $past(overrun[g]))
        else $error("result flags moved with no write or read");
      a_read_old_flags: assert property (@(posedge i_clock) disable iff (i_rst)
        slot_read[g] |=> o_rdata[1:0] == {$past(overrun[g]), $past(stored[g])})
        else $error("read did not show flags before clear");
      a_write_beats_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        slot_read[g] && slot_write[g] |=> stored[g] && !overrun[g])
        else $error("read clear beat a new result");
      a_value_read: assert property (@(posedge i_clock) disable iff (i_rst)
        slot_write[g] ##1 (slot_read[g] && !slot_write[g])
          |=> o_rdata[`ADCRS_VALUE_MSB:`ADCRS_VALUE_LSB] == $past(i_result_value, 2))
        else $error("slot value not at bits 15..6");
      a_slot_read_only: assert property (@(posedge i_clock) disable iff (i_rst)
        i_write && slot_of(i_addr) == 2'(g) && !slot_write[g]
          |=> value[g] == $past(value[g]))
        else $error("bus write changed a result slot");
      a_status_sets: assert property (@(posedge i_clock) disable iff (i_rst)
        slot_write[g] |=> irq_status[2*g])
        else $error("status bit not set by a stored result");
    end
  endgenerate

  a_zero_fields: assert property (@(posedge i_clock) disable iff (i_rst)
    $past(|slot_read) |-> o_rdata[31:16] == 16'h0000 && o_rdata[5:2] == 4'h0)
    else $error("reserved bits not zero");
  a_rdata_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_read |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_status_w1c: assert property (@(posedge i_clock) disable iff (i_rst)
    i_write && i_addr == ADDR_WIDTH'(`ADCRS_OFF_IRQ_STATUS) && next_events == '0
      |=> irq_status == ($past(irq_status) & ~$past(i_wdata[2*NSLOT-1:0])))
    else $error("status bits not cleared by a written one");
  a_mask_write: assert property (@(posedge i_clock) disable iff (i_rst)
    i_write && i_addr == ADDR_WIDTH'(`ADCRS_OFF_IRQ_MASK)
      |=> irq_mask == $past(i_wdata[2*NSLOT-1:0]))
    else $error("mask not taken from a bus write");

  c_overrun: cover property (@(posedge i_clock) disable iff (i_rst) |overrun);
  c_clash: cover property (@(posedge i_clock) disable iff (i_rst)
    |(slot_read & slot_write));
  c_read_after_store: cover property (@(posedge i_clock) disable iff (i_rst)
    slot_write[2] ##1 slot_read[2]);
  c_irq: cover property (@(posedge i_clock) disable iff (i_rst) o_irq);

endmodule // adcrs_result_slots

/* File: tb/adcrs_conv_model.sv */
// Converter core model that stores one result per request.
`timescale 1ns/100ps
module adcrs_conv_model
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [1:0] i_slot,
  input wire logic [9:0] i_value,
  output logic o_result_write,
  output logic [1:0] o_result_slot,
  output logic [9:0] o_result_value
);
  // Slot and value turn over while idle so that nothing stale looks valid.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_result_write <= 1'b0;
      o_result_slot <= 2'h0;
      o_result_value <= 10'h000;
    end
    else
    begin
      o_result_write <= i_go;
      o_result_slot <= i_go ? i_slot : ~o_result_slot;
      o_result_value <= i_go ? i_value : ~o_result_value;
    end
  end
endmodule // adcrs_conv_model

/* File: tb/testbench.sv */
// Bench for the result slots: reads, converter stores, overrun and interrupt.
`timescale 1ns/100ps
module testbench;
  logic i_clock, i_rst, i_write, i_read, go, o_irq, rw;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [1:0] slot, rs;
  logic [9:0] val, rv;
  int fail_count = 0;
  int compares = 0;
  adcrs_result_slots u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_result_write(rw), .i_result_slot(rs), .i_result_value(rv), .o_irq(o_irq));
  adcrs_conv_model u_conv (.i_clock(i_clock), .i_rst(i_rst), .i_go(go), .i_slot(slot),
    .i_value(val), .o_result_write(rw), .o_result_slot(rs), .o_result_value(rv));
  function automatic logic [31:0] w(logic [9:0] v, logic o, logic s);
    return {16'h0000, v, 4'h0, o, s};
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 chk("rdata", o_rdata, e);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic conv(logic [1:0] s, logic [9:0] v);
    @(posedge i_clock);
    go <= 1'b1;
    slot <= s;
    val <= v;
    @(posedge i_clock);
    go <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  initial
  begin
    repeat (2000) @(posedge i_clock);
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    {i_rst, i_write, i_read, go} = 4'h8;
    {i_addr, i_wdata, slot, val} = '0;
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int a = 0; a < 24; a += 4)
      rd(8'(a), 32'h0000_0000);
    conv(2'h2, 10'h3FF);
    rd(8'h0C, 32'h0000_0010);
    chk("irq", 32'(o_irq), 32'h0000_0000);
    wr(8'h10, 32'h0000_0010);
    #1 chk("irq", 32'(o_irq), 32'h0000_0001);
    wr(8'h0C, 32'h0000_0010);
    #1 chk("irq", 32'(o_irq), 32'h0000_0000);
    rd(8'h08, w(10'h3FF, 1'b0, 1'b1));
    rd(8'h08, w(10'h3FF, 1'b0, 1'b0));
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, w(10'h3FF, 1'b0, 1'b0));
    wr(8'h0C, 32'h0000_003F);
    conv(2'h1, 10'h2AA);
    conv(2'h1, 10'h001);
    rd(8'h0C, 32'h0000_000C);
    rd(8'h04, w(10'h001, 1'b1, 1'b1));
    rd(8'h04, w(10'h001, 1'b0, 1'b0));
    conv(2'h0, 10'h155);
    conv(2'h3, 10'h3FF);
    rd(8'h00, w(10'h155, 1'b0, 1'b1));
    fork
      conv(2'h0, 10'h0F0);
      begin
        @(posedge i_clock);
        rd(8'h00, w(10'h155, 1'b0, 1'b0));
      end
    join
    rd(8'h00, w(10'h0F0, 1'b0, 1'b1));
    conv(2'h2, 10'h2C3);
    rd(8'h08, w(10'h2C3, 1'b0, 1'b1));
    chk("irq", 32'(o_irq), 32'h0000_0001);
    report_and_stop();
  end
endmodule // testbench
